// >>> shared/clksw_pkg.sv
package clksw_pkg;

  // Timing base.
  localparam int CLK_PERIOD_NS = 25;
  localparam int HF_START_TIME_NS = 2000;
  localparam int HF_STABLE_TIME_NS = 1000;
  localparam int WARMUP_TIME_NS = 2000;
  localparam int PLL_LOCK_TIME_NS = 2000000;
  // Least times, rounded up to whole cycles.
  localparam int HF_START_CYC =
    (HF_START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HF_STABLE_CYC =
    (HF_STABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARMUP_CYC =
    (WARMUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_LOCK_CYC =
    (PLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] EXT_EDGES_COLD = 2'h2;
  localparam logic [1:0] EXT_EDGES_WARM = 2'h1;
  localparam int TMR_W = 17;

  // Register port.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h1;
  localparam logic [7:0] CTRL_RESET = 8'h38;
  localparam int CTRL_PLL_BIT = 7;
  localparam int CTRL_FREQ_LSB = 3;
  localparam int CTRL_SRC_LSB = 0;
  localparam int STAT_PLL_BIT = 6;
  localparam int STAT_HFR_BIT = 4;
  localparam int STAT_LFR_BIT = 1;
  localparam int STAT_HFS_BIT = 0;

  // Field encodings.
  localparam logic [3:0] FREQ_HF_8M = 4'hE;
  localparam logic [1:0] SEL_CFG = 2'h0;
  localparam logic [1:0] CFG_INTERNAL = 2'h0;

  typedef enum logic [2:0] {
    SRC_EXT = 3'b000,
    SRC_HF  = 3'b001,
    SRC_MF  = 3'b010,
    SRC_LF  = 3'b011,
    SRC_PLL = 3'b100
  } clksw_src_t;

  typedef struct packed {
    logic       pllEnableBit;
    logic [3:0] intFreqSelect;
    logic [1:0] sysClkSourceSelect;
  } clksw_ctrl_t;

  typedef struct packed {
    logic pllReadyFlag;
    logic hfOscReadyFlag;
    logic lfOscReadyFlag;
    logic hfOscStableFlag;
  } clksw_stat_t;

  typedef struct packed {
    clksw_src_t src;
    logic [3:0] divShift;
    logic [1:0] extPower;
  } clksw_sel_t;

  typedef struct packed {
    logic ext;
    logic hf;
    logic mf;
    logic lf;
    logic pll;
  } clksw_lvl_t;

  typedef struct packed {
    logic hf;
    logic lf;
    logic pll;
  } clksw_en_t;

endpackage

// >>> src/clksw_timer.sv
`timescale 1ns/1ps

module clksw_timer #(
  parameter int LIMIT = 1
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Run level and result
  input  wire logic run,
  output logic      done
);

  localparam logic [clksw_pkg::TMR_W-1:0] LAST =
    clksw_pkg::TMR_W'(LIMIT - 1);

  logic [clksw_pkg::TMR_W-1:0] count_reg;

  // Dropping run clears the count, so a restart always waits in full.
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      count_reg <= '0;
      done      <= 1'b0;
    end else if (!done) begin
      count_reg <= count_reg + 1'b1;
      done      <= (count_reg == LAST);
    end
  end

endmodule

// >>> src/clksw_regs.sv
`timescale 1ns/1ps

module clksw_regs (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [3:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrStb,
  input  wire logic              regRdStb,
  output logic      [7:0]        regRdData,
  // Block side
  input  wire clksw_pkg::clksw_stat_t stat,
  output clksw_pkg::clksw_ctrl_t ctrl
);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= clksw_pkg::clksw_ctrl_t'({
        clksw_pkg::CTRL_RESET[7:3],
        clksw_pkg::CTRL_RESET[1:0]});
    end else if (regWrStb && regAddr == clksw_pkg::CTRL_ADDR) begin
      ctrl.pllEnableBit <=
        regWrData[clksw_pkg::CTRL_PLL_BIT];
      ctrl.intFreqSelect <=
        regWrData[clksw_pkg::CTRL_FREQ_LSB +: 4];
      ctrl.sysClkSourceSelect <=
        regWrData[clksw_pkg::CTRL_SRC_LSB +: 2];
    end
  end

  // Writes to the status address fall through with no effect.
  always_ff @(posedge sys_clk) begin
    if (rst || !regRdStb) begin
      regRdData <= 8'h00;
    end else if (regAddr == clksw_pkg::CTRL_ADDR) begin
      regRdData <= {ctrl.pllEnableBit, ctrl.intFreqSelect,
                    1'b0, ctrl.sysClkSourceSelect};
    end else if (regAddr == clksw_pkg::STAT_ADDR) begin
      regRdData <= 8'h00;
      regRdData[clksw_pkg::STAT_PLL_BIT] <= stat.pllReadyFlag;
      regRdData[clksw_pkg::STAT_HFR_BIT] <= stat.hfOscReadyFlag;
      regRdData[clksw_pkg::STAT_LFR_BIT] <= stat.lfOscReadyFlag;
      regRdData[clksw_pkg::STAT_HFS_BIT] <= stat.hfOscStableFlag;
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule

// >>> src/clksw_switch_ctrl.sv
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps


module clksw_switch_ctrl #(
  parameter int PLL_LOCK_CYCLES = clksw_pkg::PLL_LOCK_CYC
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Register port
  input  wire logic [3:0]            regAddr,
  input  wire logic [7:0]            regWrData,
  input  wire logic                  regWrStb,
  input  wire logic                  regRdStb,
  output logic      [7:0]            regRdData,
  // Configuration and power events
  input  wire logic [1:0]            cfgDefaultClockSource,
  input  wire logic                  wakeFromSleep,
  // Sampled levels of the candidate clocks
  input  wire clksw_pkg::clksw_lvl_t clkLevels,
  // Clock multiplexer and oscillator control
  output clksw_pkg::clksw_sel_t      activeClk,
  output clksw_pkg::clksw_en_t       oscEnable,
  output logic                       clkHold,
  output logic                       switchBusy
);

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_WARM     = 3'b001,
    ST_START    = 3'b010,
    ST_NEW_EDGE = 3'b011,
    ST_OLD_FALL = 3'b100
  } clksw_state_t;

  //////////////////////////////////////////////////////////////////////////

  // Postscaler tap as a right shift of the 16 MHz oscillator.
  function automatic logic [3:0] freqTap(input logic [3:0] code);
    logic [3:0] tap;
    tap = 4'h0;
    case (code)
      4'hF: tap = 4'h0;
      4'hE: tap = 4'h1;
      4'hD: tap = 4'h2;
      4'hC: tap = 4'h3;
      4'hB: tap = 4'h4;
      4'hA: tap = 4'h5;
      4'h9: tap = 4'h6;
      4'h8: tap = 4'h7;
      4'h7: tap = 4'h5;
      4'h6: tap = 4'h6;
      4'h5: tap = 4'h7;
      4'h4: tap = 4'h8;
      4'h3: tap = 4'h9;
      4'h2: tap = 4'h9;
      default: tap = 4'h0;
    endcase
    return tap;
  endfunction

  // Source chosen by the control field and the configured default.
  function automatic clksw_pkg::clksw_sel_t decodeSel(
    input clksw_pkg::clksw_ctrl_t c,
    input logic [1:0]             cfg
  );
    clksw_pkg::clksw_sel_t s;
    logic                  internal;
    s = '0;
    s.extPower = cfg;
    s.divShift = freqTap(c.intFreqSelect);
    internal = c.sysClkSourceSelect[1] ||
               (cfg == clksw_pkg::CFG_INTERNAL);
    if (!internal) begin
      s.src = clksw_pkg::SRC_EXT;
    end else if (c.intFreqSelect[3:1] == 3'b000) begin
      s.src = clksw_pkg::SRC_LF;
    end else if (!c.intFreqSelect[3]) begin
      s.src = clksw_pkg::SRC_MF;
    end else if (c.pllEnableBit &&
                 c.sysClkSourceSelect == clksw_pkg::SEL_CFG) begin
      s.src = clksw_pkg::SRC_PLL;
    end else begin
      s.src = clksw_pkg::SRC_HF;
    end
    return s;
  endfunction

  // Level of one candidate clock.
  function automatic logic levelOf(
    input clksw_pkg::clksw_lvl_t l,
    input clksw_pkg::clksw_src_t s
  );
    logic v;
    v = 1'b0;
    case (s)
      clksw_pkg::SRC_EXT: v = l.ext;
      clksw_pkg::SRC_HF:  v = l.hf;
      clksw_pkg::SRC_MF:  v = l.mf;
      clksw_pkg::SRC_LF:  v = l.lf;
      clksw_pkg::SRC_PLL: v = l.pll;
      default:            v = 1'b0;
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////

  clksw_pkg::clksw_ctrl_t ctrl;
  clksw_pkg::clksw_stat_t stat;
  clksw_pkg::clksw_sel_t  wantSel;
  clksw_pkg::clksw_sel_t  tgt_reg;
  clksw_pkg::clksw_lvl_t  prevLevels_reg;
  clksw_state_t           state_reg;
  logic [1:0]             edgesLeft_reg;
  logic                   pendWake_reg;
  logic                   coldStart_reg;
  logic                   lfReady_reg;
  logic                   hfReady;
  logic                   hfStable;
  logic                   pllReady;
  logic                   warmDone;
  logic                   newFall;
  logic                   oldFall;
  logic                   tgtReady;

  clksw_regs u_regs (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .regWrStb  (regWrStb),
    .regRdStb  (regRdStb),
    .regRdData (regRdData),
    .stat      (stat),
    .ctrl      (ctrl)
  );

  // Ready and stable time run only while the oscillator is enabled.
  clksw_timer #(.LIMIT(clksw_pkg::HF_START_CYC)) u_hfTmr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (oscEnable.hf),
    .done    (hfReady)
  );

  clksw_timer #(.LIMIT(clksw_pkg::HF_STABLE_CYC)) u_hfStbTmr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (hfReady),
    .done    (hfStable)
  );

  clksw_timer #(.LIMIT(PLL_LOCK_CYCLES)) u_pllTmr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (oscEnable.pll && hfReady),
    .done    (pllReady)
  );

  clksw_timer #(.LIMIT(clksw_pkg::WARMUP_CYC)) u_warmTmr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (state_reg == ST_WARM),
    .done    (warmDone)
  );

  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    wantSel = decodeSel(ctrl, cfgDefaultClockSource);
    stat.pllReadyFlag    = pllReady;
    stat.hfOscReadyFlag  = hfReady;
    stat.lfOscReadyFlag  = lfReady_reg;
    stat.hfOscStableFlag = hfStable && hfReady;
    newFall = levelOf(prevLevels_reg, tgt_reg.src) &&
              !levelOf(clkLevels, tgt_reg.src);
    oldFall = levelOf(prevLevels_reg, activeClk.src) &&
              !levelOf(clkLevels, activeClk.src);
    case (tgt_reg.src)
      clksw_pkg::SRC_HF:  tgtReady = hfReady;
      clksw_pkg::SRC_MF:  tgtReady = hfReady;
      clksw_pkg::SRC_PLL: tgtReady = pllReady;
      default:            tgtReady = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prevLevels_reg <= '0;
    end else begin
      prevLevels_reg <= clkLevels;
    end
  end

  // The slow oscillator counts as running after its first falling edge.
  always_ff @(posedge sys_clk) begin
    if (rst || !oscEnable.lf) begin
      lfReady_reg <= 1'b0;
    end else if (prevLevels_reg.lf && !clkLevels.lf) begin
      lfReady_reg <= 1'b1;
    end
  end

  // Oscillators in use, or about to be, stay powered.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oscEnable <= '0;
    end else begin
      oscEnable.hf <=
        activeClk.src inside {clksw_pkg::SRC_HF, clksw_pkg::SRC_MF,
                              clksw_pkg::SRC_PLL} ||
        tgt_reg.src inside {clksw_pkg::SRC_HF, clksw_pkg::SRC_MF,
                            clksw_pkg::SRC_PLL} ||
        wantSel.src inside {clksw_pkg::SRC_HF, clksw_pkg::SRC_MF,
                            clksw_pkg::SRC_PLL};
      oscEnable.lf <= activeClk.src == clksw_pkg::SRC_LF ||
                      tgt_reg.src == clksw_pkg::SRC_LF ||
                      wantSel.src == clksw_pkg::SRC_LF;
      oscEnable.pll <= activeClk.src == clksw_pkg::SRC_PLL ||
                       tgt_reg.src == clksw_pkg::SRC_PLL ||
                       wantSel.src == clksw_pkg::SRC_PLL;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // Reset behaves as a power-on wake: the clock is held until the source
  // has proved itself, because nothing downstream may see a runt edge.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg     <= ST_IDLE;
      activeClk     <= '0;
      tgt_reg       <= '0;
      edgesLeft_reg <= 2'h0;
      pendWake_reg  <= 1'b1;
      coldStart_reg <= 1'b1;
      clkHold       <= 1'b1;
      switchBusy    <= 1'b0;
    end else begin
      if (wakeFromSleep) begin
        pendWake_reg  <= 1'b1;
        coldStart_reg <= 1'b1;
        clkHold       <= 1'b1;
      end
      case (state_reg)
        ST_IDLE: begin
          if (pendWake_reg) begin
            pendWake_reg <= wakeFromSleep;
            activeClk    <= wantSel;
            tgt_reg      <= wantSel;
            switchBusy   <= 1'b1;
            clkHold      <= 1'b1;
            if (wantSel.src == clksw_pkg::SRC_EXT) begin
              edgesLeft_reg <= clksw_pkg::EXT_EDGES_COLD;
              state_reg     <= ST_NEW_EDGE;
            end else if (wantSel.src == clksw_pkg::SRC_PLL) begin
              state_reg <= ST_START;
            end else begin
              state_reg <= ST_WARM;
            end
          end else if (wantSel != activeClk) begin
            tgt_reg    <= wantSel;
            switchBusy <= 1'b1;
            if (wantSel.src == activeClk.src) begin
              state_reg <= ST_OLD_FALL;
            end else begin
              state_reg <= ST_START;
            end
          end else begin
            switchBusy <= 1'b0;
          end
        end
        ST_WARM: begin
          if (warmDone) begin
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          if (tgt_reg.src == clksw_pkg::SRC_EXT) begin
            edgesLeft_reg <= coldStart_reg ?
              clksw_pkg::EXT_EDGES_COLD :
              clksw_pkg::EXT_EDGES_WARM;
            state_reg <= ST_NEW_EDGE;
          end else if (tgt_reg.src == clksw_pkg::SRC_LF) begin
            edgesLeft_reg <= clksw_pkg::EXT_EDGES_WARM;
            state_reg     <= ST_NEW_EDGE;
          end else if (tgtReady) begin
            state_reg <= clkHold ? ST_IDLE : ST_OLD_FALL;
            clkHold   <= 1'b0;
            coldStart_reg <= coldStart_reg && clkHold;
          end
        end
        ST_NEW_EDGE: begin
          if (newFall) begin
            edgesLeft_reg <= edgesLeft_reg - 2'h1;
            if (edgesLeft_reg == 2'h1) begin
              state_reg <= clkHold ? ST_IDLE : ST_OLD_FALL;
              clkHold   <= 1'b0;
            end
          end
        end
        ST_OLD_FALL: begin
          // Swapping right after a falling edge keeps both phases whole.
          if (oldFall) begin
            activeClk     <= tgt_reg;
            coldStart_reg <= 1'b0;
            state_reg     <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> tb/clksw_checker.sv
`timescale 1ns/1ps

module clksw_checker #(
  parameter int PLL_LOCK_CYCLES = 20
) (
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst,
  // Register port
  input wire logic [3:0]             regAddr,
  input wire logic [7:0]             regWrData,
  input wire logic                   regWrStb,
  input wire logic                   regRdStb,
  input wire logic [7:0]             regRdData,
  // Configuration, power events and clock levels
  input wire logic [1:0]             cfgDefaultClockSource,
  input wire logic                   wakeFromSleep,
  input wire clksw_pkg::clksw_lvl_t  clkLevels,
  // Multiplexer side
  input wire clksw_pkg::clksw_sel_t  activeClk,
  input wire clksw_pkg::clksw_en_t   oscEnable,
  input wire logic                   clkHold,
  input wire logic                   switchBusy
);
  logic [7:0]            ctrl_reg;
  clksw_pkg::clksw_sel_t lastSel_reg;
  logic                  lvlPrev_reg;
  logic                  fellSeen_reg;
  logic                  curLvl;
  logic                  rdCtrl;
  logic                  rdStat;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // The struct runs ext..pll from the top, so the index is 4 minus the code.
  assign curLvl = clkLevels[3'h4 - activeClk.src];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= clksw_pkg::CTRL_RESET;
    end else if (regWrStb && regAddr == clksw_pkg::CTRL_ADDR) begin
      ctrl_reg <= regWrData;
    end
  end

  // A handover is legal only in the cycle right after the old clock falls,
  // so an older edge cannot excuse a late, phase-cutting swap.
  always_ff @(posedge sys_clk) begin
    lastSel_reg  <= activeClk;
    lvlPrev_reg  <= curLvl;
    fellSeen_reg <= !rst && lvlPrev_reg && !curLvl;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    rdCtrl <= regRdStb && regAddr == clksw_pkg::CTRL_ADDR;
    rdStat <= regRdStb && regAddr == clksw_pkg::STAT_ADDR;
  end

  chk_stat_unused_zero: assert property (
    rdStat |-> (regRdData & 8'hAC) == 8'h00)
    else $error("status unused bits not zero");
  chk_ctrl_gap_zero: assert property (
    rdCtrl |-> !regRdData[2])
    else $error("control bit 2 not zero");
  chk_ctrl_readback: assert property (
    rdCtrl |-> regRdData == (ctrl_reg & 8'hFB))
    else $error("control readback differs");
  chk_stable_needs_ready: assert property (
    rdStat |-> !regRdData[0] || regRdData[4])
    else $error("stable without ready");
  chk_pll_only_sel00: assert property (
    $fell(switchBusy) && activeClk.src == clksw_pkg::SRC_PLL
      |-> ctrl_reg[1:0] == 2'h0 && ctrl_reg[7])
    else $error("pll applied with wrong select");
  chk_switch_bound: assert property (
    $rose(switchBusy) |-> ##[1:1000] !switchBusy)
    else $error("switch never ended");
  chk_mux_handover: assert property (
    activeClk != lastSel_reg && !clkHold && !$past(clkHold)
      |-> fellSeen_reg)
    else $error("mux changed without falling edge");
  chk_wake_hold: assert property (
    wakeFromSleep && !clkHold |-> ##[1:2] clkHold ##[1:1000] !clkHold)
    else $error("wake hold wrong");
  chk_reset_state: assert property (
    $fell(rst) |-> activeClk == '0 && clkHold && !switchBusy)
    else $error("state after reset wrong");

  cover property (activeClk.src == clksw_pkg::SRC_PLL);
  cover property (activeClk.src == clksw_pkg::SRC_LF);
  cover property (activeClk.src == clksw_pkg::SRC_EXT);
  cover property (wakeFromSleep);
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps

module tb;
  logic                  sys_clk, rst, regWrStb, regRdStb, wakeFromSleep;
  logic [3:0]            regAddr;
  logic [7:0]            regWrData, regRdData, rdVal, got, exp;
  logic [7:0]            phase = 8'h00;
  logic [1:0]            cfgDefaultClockSource;
  logic                  clkHold, switchBusy;
  clksw_pkg::clksw_lvl_t clkLevels = '0;
  clksw_pkg::clksw_sel_t activeClk;
  clksw_pkg::clksw_en_t  oscEnable;
  int                    errors, total_checks, waited;

  clksw_switch_ctrl #(.PLL_LOCK_CYCLES(20)) DUT (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .cfgDefaultClockSource(cfgDefaultClockSource),
    .wakeFromSleep(wakeFromSleep), .clkLevels(clkLevels),
    .activeClk(activeClk), .oscEnable(oscEnable), .clkHold(clkHold),
    .switchBusy(switchBusy));

  always #12.5 sys_clk = ~sys_clk;

  // A powered-off oscillator holds its output low.
  always @(posedge sys_clk) begin
    phase <= phase + 8'h01;
    clkLevels <= {phase[1], oscEnable.hf & phase[0], oscEnable.hf & phase[1],
                  oscEnable.lf & phase[3], oscEnable.pll & phase[0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic cmp_sel(input logic [7:0] e);
    cmp({1'b0, activeClk.src, activeClk.divShift}, e);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 rdVal = regRdData;
  endtask

  // Bounded wait for the switch and any clock hold to finish.
  task automatic wait_idle();
    waited = 0;
    repeat (3) @(posedge sys_clk);
    #1;
    while ((switchBusy !== 1'b0 || clkHold !== 1'b0) && waited < 3000) begin
      @(posedge sys_clk);
      #1 waited++;
    end
    if (waited >= 3000) begin
      errors++;
      final_report();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    wakeFromSleep = 1'b0;
    cfgDefaultClockSource = 2'h0;
    errors = 0;
    total_checks = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h0);
    cmp(rdVal, 8'h38);
    wait_idle();
    cmp_sel({1'b0, clksw_pkg::SRC_MF, 4'h5});
    repeat (150) @(posedge sys_clk);
    rd(4'h1);
    cmp(rdVal & 8'hFD, 8'h11);
    wr(4'h1, 8'hFF);
    rd(4'h1);
    cmp(rdVal & 8'hFD, 8'h11);
    wr(4'h0, 8'hFF);
    rd(4'h0);
    cmp(rdVal, 8'hFB);
    wait_idle();
    cmp_sel({1'b0, clksw_pkg::SRC_HF, 4'h0});
    for (int f = 15; f >= 0; f--) begin
      wr(4'h0, {1'b0, 4'(f), 3'b010});
      wait_idle();
      if (f == 14) cmp({7'h00, waited < 40}, 8'h01);
      if (f >= 8) exp = {1'b0, clksw_pkg::SRC_HF, 4'(15 - f)};
      else if (f >= 4) exp = {1'b0, clksw_pkg::SRC_MF, 4'(12 - f)};
      else if (f >= 2) exp = {1'b0, clksw_pkg::SRC_MF, 4'h9};
      else exp = {1'b0, clksw_pkg::SRC_LF, 4'h0};
      got = {1'b0, activeClk.src, f < 2 ? 4'h0 : activeClk.divShift};
      cmp(got, exp);
    end
    rd(4'h1);
    cmp(rdVal, 8'h02);
    cmp({5'h00, oscEnable}, 8'h02);
    wr(4'h0, 8'hF0);
    wait_idle();
    got = {5'h00, activeClk.src};
    cmp(got, {5'h00, clksw_pkg::SRC_PLL});
    cmp({7'h00, waited + 3 >= clksw_pkg::HF_START_CYC}, 8'h01);
    rd(4'h1);
    cmp(rdVal & 8'h40, 8'h40);
    wr(4'h0, 8'hF2);
    wait_idle();
    cmp_sel({1'b0, clksw_pkg::SRC_HF, 4'h1});
    wr(4'h0, 8'hF1);
    wait_idle();
    cmp_sel({1'b0, clksw_pkg::SRC_HF, 4'h1});
    for (int c = 3; c >= 1; c--) begin
      @(posedge sys_clk);
      cfgDefaultClockSource <= 2'(c);
      wr(4'h0, 8'h38 | 8'(c & 1));
      wait_idle();
      got = {3'h0, activeClk.src, activeClk.extPower};
      cmp(got, {3'h0, clksw_pkg::SRC_EXT, 2'(c)});
    end
    @(posedge sys_clk);
    cfgDefaultClockSource <= 2'h0;
    wr(4'h0, 8'h3A);
    wait_idle();
    @(posedge sys_clk);
    wakeFromSleep <= 1'b1;
    @(posedge sys_clk);
    wakeFromSleep <= 1'b0;
    @(posedge sys_clk);
    #1 cmp({7'h00, clkHold}, 8'h01);
    wait_idle();
    cmp_sel({1'b0, clksw_pkg::SRC_MF, 4'h5});
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h0);
    cmp(rdVal, 8'h38);
    final_report();
  end
endmodule

bind clksw_switch_ctrl clksw_checker
  #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .cfgDefaultClockSource(cfgDefaultClockSource),
  .wakeFromSleep(wakeFromSleep), .clkLevels(clkLevels),
  .activeClk(activeClk), .oscEnable(oscEnable), .clkHold(clkHold),
  .switchBusy(switchBusy));
